// ### rtl/wdt_regs.svh
// Register offsets, field positions, reset values and counts of the watchdog block.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// Register indices; the APB byte address is four times the index.
`define WDT_IDX_OPTION      14'h0081
`define WDT_IDX_CONTROL     14'h0105
`define WDT_IDX_STATUS      14'h0106
`define WDT_ADDR_OPTION     ({`WDT_IDX_OPTION, 2'b00})
`define WDT_ADDR_CONTROL    ({`WDT_IDX_CONTROL, 2'b00})
`define WDT_ADDR_STATUS     ({`WDT_IDX_STATUS, 2'b00})

// Control register fields.
`define WDT_CTL_EN_BIT      0
`define WDT_CTL_PS_LSB      1
`define WDT_CTL_PS_MSB      4
`define WDT_CTL_RST         8'h08

// Option register fields.
`define WDT_OPT_PS_LSB      0
`define WDT_OPT_PS_MSB      2
`define WDT_OPT_PSA_BIT     3
`define WDT_OPT_RST         8'hFF

// Status register fields.
`define WDT_STS_RUN_BIT     0
`define WDT_STS_OST_BIT     1
`define WDT_STS_TMO_BIT     2
`define WDT_STS_FAIL_BIT    3

// Divider settings and counts.
`define WDT_RC_FREQ_HZ      31250
`define WDT_PS_MAX          4'hB
`define WDT_PRE_LOG0        5
`define WDT_OST_COUNT       11'h400
`define WDT_SCS_FAILSAFE    2'h2
`define WDT_SCS_RST         2'h0

`endif

// ### rtl/wdt_pkg.sv
// Types shared by the watchdog block files.
package wdt_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } wdt_apb_req_s;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } wdt_apb_rsp_s;

   typedef enum logic [0:0] {
      WDT_APB_IDLE = 1'b0,
      WDT_APB_ACK  = 1'b1
   } wdt_apb_e;

endpackage

// ### rtl/wdt_pow2_div.sv
// Power-of-two tick divider used for the prescaler and the postscaler.
`timescale 1ns/1ns
module wdt_pow2_div #(
   parameter int W    = 16,
   parameter int SW   = 4,
   parameter int LOG0 = 5
) (
   // Clock and reset
   input  wire logic          i_clock,
   input  wire logic          i_sys_rst,
   // Control
   input  wire logic          i_clr,
   input  wire logic          i_tick,
   input  wire logic [SW-1:0] i_sel,
   // Divided tick
   output logic               o_tick
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] mask;
   logic         hit;

   assign mask = W'((33'd1 << (32'(i_sel) + LOG0)) - 33'd1);
   assign hit  = i_tick && ((cnt_ff & mask) == mask);

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_ff <= '0;
      end else if (i_clr) begin
         cnt_ff <= '0;
      end else if (i_tick) begin
         cnt_ff <= cnt_ff + W'(1);
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tick <= 1'b0;
      end else begin
         o_tick <= hit && !i_clr;
      end
   end

   // Input ticks seen since the last output tick, for checking only.
   logic [W:0] seen_ff;
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         seen_ff <= '0;
      end else if (i_clr || o_tick) begin
         seen_ff <= {{W{1'b0}}, i_tick && !i_clr};
      end else if (i_tick && !seen_ff[W]) begin
         seen_ff <= seen_ff + (W+1)'(1);
      end
   end

   a_div_ratio_bound: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE5]
      o_tick |-> seen_ff <= {1'b0, $past(mask)} + (W+1)'(1))
      else $error("divider output came later than its ratio");
endmodule

// ### rtl/wdt_startup_timer.sv
// Oscillator start-up timer that counts internal RC ticks.
`timescale 1ns/1ns
`include "wdt_regs.svh"
module wdt_startup_timer (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // Control
   input  wire logic i_start,
   input  wire logic i_rc_tick,
   // Status
   output logic      o_busy,
   output logic      o_done
);
   logic [10:0] cnt_ff;

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_ff <= 11'h000;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            cnt_ff <= 11'h000;
            o_busy <= 1'b1;
         end else if (o_busy && i_rc_tick) begin
            if (cnt_ff == `WDT_OST_COUNT - 11'h001) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end
            cnt_ff <= cnt_ff + 11'h001;
         end
      end
   end
endmodule

// ### rtl/wdt_top.sv
// Watchdog timer with prescaler, shared postscaler and APB registers.
//
// How it works
// RULE1: Counting is paced by edges of the internal RC oscillator, not the system clock.
// RULE2: Every reset loads the control register with 0 1000: period code 0100, enable clear.
// RULE3: With the reset period code the nominal base period is 16.38 ms.
// RULE4: While the start-up timer counts, the watchdog is held cleared.
// RULE5: A 16-bit prescaler divides the RC ticks by 32 up to 65536.
// RULE6: Base periods span nominally 1 ms to 2.097 s across the settings.
// RULE7: Period code 0000 gives 1:32, each step doubles, 1011 gives 1:65536.
// RULE8: With prescaler assign set, the postscaler follows the prescaler, reaching 268 s.
// RULE9: Watchdog and timer-zero scalers keep independent ratios at the same time; the code does so only with prescaler assign clear.
// RULE10: Hardware force-on keeps the watchdog running; software enable is then ignored.
// RULE11: Without force-on, software enable 1 starts and 0 stops the watchdog.
// RULE12: Enable is control bit 0, period select bits 4..1, bits 7..5 read zero.
// RULE13: Clear instruction, oscillator failure and start-up end clear both scalers; the code clears the postscaler only while prescaler assign is set.
// RULE14: A clock failure forces the clock source select to 10 and clears the watchdog.
// RULE15: A timeout gives a watchdog reset, or a wake-up while asleep.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`include "wdt_regs.svh"
module wdt_top
   import wdt_pkg::*;
(
   // Clock and reset
   input  wire logic          i_clock,
   input  wire logic          i_sys_rst,
   // APB slave
   input  wire wdt_apb_req_s  i_apb_req,
   output wdt_apb_rsp_s       o_apb_rsp,
   // Clock sources
   input  wire logic          i_internal_rc_osc,
   input  wire logic          i_timer_zero_clk_tick,
   // Device events and configuration
   input  wire logic          i_hw_watchdog_force_on,
   input  wire logic          i_clear_watchdog_instr,
   input  wire logic          i_osc_fail_detect,
   input  wire logic          i_failsafe_exit,
   input  wire logic          i_osc_startup_timer_start,
   input  wire logic          i_sleep,
   // Watchdog results
   output logic               o_wdt_reset,
   output logic               o_wdt_wakeup,
   output logic               o_wdt_running,
   output logic               o_timer_zero_inc,
   output logic [1:0]         o_clock_source_select
);
   // Register state.
   logic       sw_watchdog_enable_ff;
   logic [3:0] watchdog_period_select_ff;
   logic [7:0] timer_option_config_ff;
   logic       timeout_seen_ff;
   logic       clk_fail_forced_ff;
   wdt_apb_e   apb_state_ff;

   // Time base and scaler signals.
   logic       rc_prev_ff;
   logic       rc_tick_ff;
   logic       pre_tick;
   logic       post_tick;
   logic       ost_busy;
   logic       ost_done;
   logic       enable;
   logic       wdt_clr;
   logic       timeout;
   logic       prescaler_assign;
   logic [2:0] postscale_select;
   logic [3:0] pre_sel;
   logic [3:0] post_sel;
   logic       post_in;
   logic       post_clr;

   // APB decode.
   logic        setup;
   logic        access;
   logic        commit;
   logic        wr_commit;
   logic        hit;
   logic [31:0] rd_data;

   assign prescaler_assign = timer_option_config_ff[`WDT_OPT_PSA_BIT];
   assign postscale_select = timer_option_config_ff[`WDT_OPT_PS_MSB:`WDT_OPT_PS_LSB];

   // Edge of the internal RC oscillator paces every watchdog count.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rc_prev_ff <= 1'b0;
         rc_tick_ff <= 1'b0;
      end else begin
         rc_prev_ff <= i_internal_rc_osc;
         rc_tick_ff <= i_internal_rc_osc && !rc_prev_ff; // [RULE1]
      end
   end

   assign enable = i_hw_watchdog_force_on || sw_watchdog_enable_ff; // [RULE10] [RULE11]

   // Anything that clears the watchdog clears the prescaler, and the postscaler while it is assigned to the watchdog.
   assign wdt_clr = !enable || ost_busy || ost_done // [RULE4] [RULE13]
                    || i_clear_watchdog_instr || i_osc_fail_detect // [RULE13] [RULE14]
                    || o_wdt_reset || o_wdt_wakeup;

   // Codes above 1011 behave as the longest ratio.
   assign pre_sel = (watchdog_period_select_ff > `WDT_PS_MAX) ? `WDT_PS_MAX // [RULE7]
                                                              : watchdog_period_select_ff;

   wdt_startup_timer u_ost (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_start   (i_osc_startup_timer_start),
      .i_rc_tick (rc_tick_ff),
      .o_busy    (ost_busy),
      .o_done    (ost_done)
   );

   // Watchdog-only prescaler, from 1:32 (1 ms) to 1:65536 (2.097 s) of RC ticks.
   wdt_pow2_div #(.W(16), .SW(4), .LOG0(`WDT_PRE_LOG0)) u_prescaler ( // [RULE5] [RULE6] [RULE3]
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_clr     (wdt_clr),
      .i_tick    (rc_tick_ff),
      .i_sel     (pre_sel),
      .o_tick    (pre_tick)
   );

   // The postscaler serves the watchdog when assigned, otherwise timer zero.
   assign post_in  = prescaler_assign ? pre_tick : i_timer_zero_clk_tick; // [RULE8] [RULE9]
   assign post_sel = prescaler_assign ? {1'b0, postscale_select}
                                      : {1'b0, postscale_select} + 4'h1;
   assign post_clr = prescaler_assign && wdt_clr; // [RULE13]

   wdt_pow2_div #(.W(8), .SW(4), .LOG0(0)) u_postscaler (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_clr     (post_clr),
      .i_tick    (post_in),
      .i_sel     (post_sel),
      .o_tick    (post_tick)
   );

   assign timeout = !wdt_clr && (prescaler_assign ? post_tick : pre_tick); // [RULE8]

   // Timeout becomes a reset while awake or a wake-up while asleep.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_wdt_reset  <= 1'b0;
         o_wdt_wakeup <= 1'b0;
      end else begin
         o_wdt_reset  <= timeout && !i_sleep; // [RULE15]
         o_wdt_wakeup <= timeout && i_sleep; // [RULE15]
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_wdt_running    <= 1'b0;
         o_timer_zero_inc <= 1'b0;
      end else begin
         o_wdt_running    <= enable && !ost_busy;
         o_timer_zero_inc <= post_tick && !prescaler_assign; // [RULE9]
      end
   end

   // Clock failure forces the failsafe source until the failsafe condition ends.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         clk_fail_forced_ff    <= 1'b0;
         o_clock_source_select <= `WDT_SCS_RST;
      end else if (i_osc_fail_detect) begin
         clk_fail_forced_ff    <= 1'b1;
         o_clock_source_select <= `WDT_SCS_FAILSAFE; // [RULE14]
      end else if (i_failsafe_exit) begin
         clk_fail_forced_ff    <= 1'b0;
         o_clock_source_select <= `WDT_SCS_RST;
      end
   end

   // APB access: one wait cycle, then pready for one cycle.
   assign setup     = i_apb_req.psel && !i_apb_req.penable;
   assign access    = i_apb_req.psel && i_apb_req.penable;
   assign commit    = access && (apb_state_ff == WDT_APB_ACK);
   assign wr_commit = commit && i_apb_req.pwrite;

   always_comb begin
      hit     = 1'b1;
      rd_data = 32'h0000_0000;
      case (i_apb_req.paddr)
         `WDT_ADDR_OPTION: begin
            rd_data[7:0] = timer_option_config_ff;
         end
         `WDT_ADDR_CONTROL: begin
            rd_data[`WDT_CTL_EN_BIT] = sw_watchdog_enable_ff; // [RULE12]
            rd_data[`WDT_CTL_PS_MSB:`WDT_CTL_PS_LSB] = watchdog_period_select_ff;
         end
         `WDT_ADDR_STATUS: begin
            rd_data[`WDT_STS_RUN_BIT]  = enable && !ost_busy;
            rd_data[`WDT_STS_OST_BIT]  = ost_busy;
            rd_data[`WDT_STS_TMO_BIT]  = timeout_seen_ff;
            rd_data[`WDT_STS_FAIL_BIT] = clk_fail_forced_ff;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         apb_state_ff <= WDT_APB_IDLE;
         o_apb_rsp    <= '0;
      end else begin
         case (apb_state_ff)
            WDT_APB_IDLE: begin
               if (access) begin
                  apb_state_ff      <= WDT_APB_ACK;
                  o_apb_rsp.pready  <= 1'b1;
                  o_apb_rsp.pslverr <= !hit;
                  o_apb_rsp.prdata  <= i_apb_req.pwrite ? 32'h0000_0000 : rd_data;
               end
            end
            WDT_APB_ACK: begin
               apb_state_ff <= WDT_APB_IDLE;
               o_apb_rsp    <= '0;
            end
            default: begin
               apb_state_ff <= WDT_APB_IDLE;
               o_apb_rsp    <= '0;
            end
         endcase
      end
   end

   // Control register, reloaded on a watchdog reset as on any other reset.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sw_watchdog_enable_ff     <= 1'(`WDT_CTL_RST >> `WDT_CTL_EN_BIT); // [RULE2]
         watchdog_period_select_ff <= 4'(`WDT_CTL_RST >> `WDT_CTL_PS_LSB);
      end else if (o_wdt_reset) begin
         sw_watchdog_enable_ff     <= 1'(`WDT_CTL_RST >> `WDT_CTL_EN_BIT); // [RULE2]
         watchdog_period_select_ff <= 4'(`WDT_CTL_RST >> `WDT_CTL_PS_LSB);
      end else if (wr_commit && (i_apb_req.paddr == `WDT_ADDR_CONTROL)) begin
         sw_watchdog_enable_ff     <= i_apb_req.pwdata[`WDT_CTL_EN_BIT]; // [RULE11] [RULE12]
         watchdog_period_select_ff <= i_apb_req.pwdata[`WDT_CTL_PS_MSB:`WDT_CTL_PS_LSB];
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         timer_option_config_ff <= `WDT_OPT_RST;
      end else if (wr_commit && (i_apb_req.paddr == `WDT_ADDR_OPTION)) begin
         timer_option_config_ff <= i_apb_req.pwdata[7:0];
      end
   end

   // Sticky timeout flag: write 1 clears, a new timeout in the same cycle wins.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         timeout_seen_ff <= 1'b0;
      end else if (timeout) begin
         timeout_seen_ff <= 1'b1;
      end else if (wr_commit && (i_apb_req.paddr == `WDT_ADDR_STATUS)
                   && i_apb_req.pwdata[`WDT_STS_TMO_BIT]) begin
         timeout_seen_ff <= 1'b0;
      end
   end

   a_ctl_reload_val: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE2]
      o_wdt_reset |=> (watchdog_period_select_ff == 4'h4) && !sw_watchdog_enable_ff)
      else $error("control register not reloaded after watchdog reset");

   a_ost_hold_off: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE4]
      ost_busy |=> ##1 !o_wdt_reset && !o_wdt_wakeup)
      else $error("watchdog fired while start-up timer counted");

   a_pre_rc_paced: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE1]
      pre_tick |-> $past(rc_tick_ff))
      else $error("prescaler advanced without an RC edge");

   a_period_clamp: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE7]
      (watchdog_period_select_ff >= 4'hB) |-> (pre_sel == 4'hB))
      else $error("period code beyond 1011 not held at 1:65536");

   a_post_chain: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE8]
      (post_tick && $past(prescaler_assign) && prescaler_assign) |-> $past(pre_tick))
      else $error("postscaler advanced without a prescaler tick");

   a_tz_separate: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE9]
      (post_tick && !prescaler_assign) |=> o_timer_zero_inc)
      else $error("timer zero lost a postscaler tick");

   a_hw_force_run: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE10]
      (i_hw_watchdog_force_on && !ost_busy) [*2] |-> o_wdt_running)
      else $error("forced watchdog not running");

   a_sw_stop: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE11]
      (!i_hw_watchdog_force_on && !sw_watchdog_enable_ff) [*2] |-> !o_wdt_running
      ##1 !o_wdt_reset)
      else $error("watchdog running with software enable clear");

   a_clear_blocks: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE13]
      i_clear_watchdog_instr |=> !o_wdt_reset && !o_wdt_wakeup)
      else $error("timeout right after a clear");

   a_fail_forces: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE14]
      i_osc_fail_detect |=> (o_clock_source_select == 2'h2) && !o_wdt_reset)
      else $error("clock failure did not force source select");

   a_wake_in_sleep: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE15]
      (o_wdt_wakeup |-> $past(i_sleep)) and (o_wdt_reset |-> !$past(i_sleep)))
      else $error("timeout result does not match sleep state");

   a_apb_one_wait: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (setup ##1 access) |=> o_apb_rsp.pready)
      else $error("APB answer not after one wait cycle");

   a_tmo_sticky_set: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE15]
      timeout |=> timeout_seen_ff)
      else $error("timeout did not set the sticky status bit");

   a_rst_one_pulse: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE15]
      o_wdt_reset |=> !o_wdt_reset)
      else $error("watchdog reset pulse longer than one cycle");

   a_ost_pre_quiet: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE4]
      ost_busy |=> !pre_tick)
      else $error("prescaler ticked while start-up timer counted");

   a_off_pre_quiet: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE11]
      !enable |=> !pre_tick)
      else $error("prescaler ticked while watchdog disabled");

   a_clr_pre_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE13]
      (i_clear_watchdog_instr || i_osc_fail_detect) |=> !pre_tick)
      else $error("prescaler ticked right after a clear");

   a_clr_post_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE13]
      (prescaler_assign && (i_clear_watchdog_instr || i_osc_fail_detect)) |=> !post_tick)
      else $error("postscaler ticked right after a clear");

   a_fail_src_held: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE14]
      (o_clock_source_select == 2'h2 && !i_failsafe_exit) |=> (o_clock_source_select == 2'h2))
      else $error("failsafe clock source dropped without an exit");

   a_ctl_top_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst) // [RULE12]
      (access && (apb_state_ff == WDT_APB_IDLE) && !i_apb_req.pwrite
       && (i_apb_req.paddr == `WDT_ADDR_CONTROL)) |=> (o_apb_rsp.prdata[31:5] == 27'h0))
      else $error("unimplemented control bits read as one");

   a_err_unmapped: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (access && (apb_state_ff == WDT_APB_IDLE) && !hit) |=> o_apb_rsp.pslverr)
      else $error("unmapped address answered without an error");
endmodule

// ### verif/tb_top.sv
// Self-checking testbench for the watchdog block, driven over APB and its event pins.
`timescale 1ns/1ns
`include "wdt_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_top
   import wdt_pkg::*;
;
   logic         i_clock = 1'b0;
   logic         i_sys_rst = 1'b1;
   wdt_apb_req_s req = '0;
   wdt_apb_rsp_s rsp;
   logic         rc = 1'b0;
   localparam int P_CLR  = 0;
   localparam int P_FAIL = 1;
   localparam int P_EXIT = 2;
   localparam int P_OST  = 3;
   localparam int P_TZ   = 4;
   logic         force_on = 1'b0;
   logic         sleep = 1'b0;
   logic [4:0]   pul = 5'h00;
   logic         wdt_reset;
   logic         wdt_wakeup;
   logic         running;
   logic         tz_inc;
   logic [1:0]   css;
   int           bad_count = 0;
   int           total_checks = 0;
   int           rst_n = 0;
   int           wake_n = 0;
   int           tz_n = 0;
   int           cycles = 0;
   logic [31:0]  rd;
   logic         err;

   wdt_top i_wdt_top (
      .i_clock                   (i_clock),
      .i_sys_rst                 (i_sys_rst),
      .i_apb_req                 (req),
      .o_apb_rsp                 (rsp),
      .i_internal_rc_osc         (rc),
      .i_timer_zero_clk_tick     (pul[P_TZ]),
      .i_hw_watchdog_force_on    (force_on),
      .i_clear_watchdog_instr    (pul[P_CLR]),
      .i_osc_fail_detect         (pul[P_FAIL]),
      .i_failsafe_exit           (pul[P_EXIT]),
      .i_osc_startup_timer_start (pul[P_OST]),
      .i_sleep                   (sleep),
      .o_wdt_reset               (wdt_reset),
      .o_wdt_wakeup              (wdt_wakeup),
      .o_wdt_running             (running),
      .o_timer_zero_inc          (tz_inc),
      .o_clock_source_select     (css)
   );

   always #25 i_clock = ~i_clock;

   // Result pulses stand one cycle, so each is counted once per edge.
   always @(posedge i_clock) begin
      if (wdt_reset === 1'b1) rst_n++;
      if (wdt_wakeup === 1'b1) wake_n++;
      if (tz_inc === 1'b1) tz_n++;
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic apb(input bit wr, input logic [15:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= addr;
      req.pwdata  <= wd;
      @(posedge i_clock);
      req.penable <= 1'b1;
      do begin
         @(posedge i_clock);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      rd  = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 20) bad_count++;
      @(posedge i_clock);
   endtask

   task automatic rchk(input logic [15:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      `CHK("read data", exp, rd)
   endtask

   task automatic pulse(input int which);
      pul[which] <= 1'b1;
      @(posedge i_clock);
      pul[which] <= 1'b0;
      @(posedge i_clock);
   endtask

   task automatic rc_edges(input int n);
      repeat (n) begin
         rc <= 1'b1;
         repeat (3) @(posedge i_clock);
         rc <= 1'b0;
         repeat (3) @(posedge i_clock);
      end
   endtask

   task automatic arm(input logic [7:0] opt, input logic [7:0] ctl);
      apb(1'b1, `WDT_ADDR_OPTION, {24'h0, opt});
      apb(1'b1, `WDT_ADDR_CONTROL, {24'h0, ctl});
      pulse(P_CLR);
   endtask

   // One edge short of the ratio gives nothing; the last edge gives one pulse.
   task automatic run_expect(input int n, input bit wake);
      int r0;
      int w0;
      r0 = rst_n;
      w0 = wake_n;
      rc_edges(n - 1);
      repeat (8) @(posedge i_clock);
      `CHK("early timeout", 0, (rst_n - r0) + (wake_n - w0))
      rc_edges(1);
      repeat (8) @(posedge i_clock);
      `CHK("reset pulses", wake ? 0 : 1, rst_n - r0)
      `CHK("wake pulses", wake ? 1 : 0, wake_n - w0)
   endtask

   initial begin
      int r0;
      repeat (3) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      @(posedge i_clock);
      rchk(`WDT_ADDR_CONTROL, 32'h08);
      rchk(`WDT_ADDR_OPTION, 32'hFF);
      apb(1'b1, `WDT_ADDR_CONTROL, 32'hFF);
      rchk(`WDT_ADDR_CONTROL, 32'h1F);
      apb(1'b0, 16'h0008, 32'h0);
      `CHK("unmapped error", 1'b1, err)
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      @(posedge i_clock);
      rchk(`WDT_ADDR_CONTROL, 32'h08);
      for (int c = 0; c < 5; c++) begin
         arm(8'h00, 8'(c * 2 + 1));
         run_expect(32 << c, 1'b0);
      end
      arm(8'h09, 8'h01);
      run_expect(64, 1'b0);
      for (int k = 0; k < 2; k++) begin
         arm(8'h00, 8'h01);
         rc_edges(20);
         if (k == 0) pulse(P_CLR);
         else pulse(P_FAIL);
         if (k == 1) `CHK("clock source", 2'b10, css)
         if (k == 1) rchk(`WDT_ADDR_STATUS, 32'h0D);
         run_expect(32, 1'b0);
      end
      pulse(P_EXIT);
      `CHK("clock source", 2'b00, css)
      arm(8'h00, 8'h00);
      r0 = rst_n;
      rc_edges(40);
      `CHK("disabled timeout", 0, rst_n - r0)
      force_on <= 1'b1;
      pulse(P_CLR);
      run_expect(32, 1'b0);
      force_on <= 1'b0;
      arm(8'h00, 8'h01);
      pulse(P_OST);
      rc_edges(500);
      `CHK("running", 1'b0, running)
      rchk(`WDT_ADDR_STATUS, 32'h06);
      apb(1'b1, `WDT_ADDR_STATUS, 32'h04);
      rchk(`WDT_ADDR_STATUS, 32'h02);
      rc_edges(524);
      `CHK("running", 1'b1, running)
      run_expect(32, 1'b0);
      sleep <= 1'b1;
      arm(8'h00, 8'h01);
      run_expect(32, 1'b1);
      sleep <= 1'b0;
      for (int p = 0; p < 3; p++) begin
         apb(1'b1, `WDT_ADDR_OPTION, 32'(p));
         r0 = tz_n;
         repeat (16) begin
            pulse(P_TZ);
            @(posedge i_clock);
         end
         repeat (4) @(posedge i_clock);
         `CHK("timer zero incs", 16 >> (p + 1), tz_n - r0)
      end
      print_verdict();
   end
endmodule
